/* File: bench/pd_msg_regs_tb_top.sv */
`default_nettype none
module pd_msg_regs_tb_top
  import pd_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(g, e) begin \
  checkCount++; \
  if ((g) !== (e)) begin \
    nErrors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); \
  end \
end

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic controllerIdle = 1'b0;
  logic sleepActive;
  logic [PIN_LO_N-1:0] pinLevelLo = '0;
  logic [PIN_HI_N-1:0] pinLevelHi = '0;
  logic [PIN_LO_N-1:0] pinDirOut = '0;
  logic jackPin = 1'b0;
  logic jackEventEnable = 1'b0;
  logic srcInfoUpdate = 1'b0;
  logic [DATA_W-1:0] srcInfoValue = '0;
  // identity values are arbitrary
  fw_ident_s fwIdent = {16'h1111, 16'h2222, 32'h3333_4444, 32'h5555_6666};
  logic [15:0] hwRev = 16'h5a5a;
  logic msgReq;
  msg_kind_e msgKind;
  logic replyValid;
  reply_s reply;
  int nErrors = 0;
  int checkCount = 0;
  int cycles = 0;

  typedef struct packed {
    logic [7:0] ofs;
    logic [1:0] w;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;

  row_s rows[13] = '{
    {8'h70, 2'h0, 32'hffff_ffff, 32'h0000_0007},
    {8'h70, 2'h0, 32'h0000_0004, 32'h0000_0004},
    {8'h42, 2'h0, 32'hffff_ffff, 32'h0000_0007},
    {8'h7a, 2'h0, 32'hffff_ffff, 32'h0eff_ffff},
    {8'h77, 2'h0, 32'hffff_ffff, 32'hffff_ffff},
    {8'h77, 2'h1, 32'hffff_ffff, 32'hffff_ffff},
    {8'h77, 2'h2, 32'hffff_ffff, 32'hffff_ffff},
    {8'h77, 2'h3, 32'hffff_ff13, 32'h00ff_7f13},
    {8'h78, 2'h0, 32'hffff_ffff, 32'h0000_0000},
    {8'h72, 2'h0, 32'hffff_ffff, 32'h0000_0000},
    {8'h72, 2'h1, 32'hffff_ffff, 32'h0000_0000},
    {8'h10, 2'h0, 32'hffff_ffff, 32'h0000_0000},
    {8'h70, 2'h1, 32'hffff_ffff, 32'h0000_0000}
  };

  always #50 clk = ~clk;

  pd_msg_regs #(.SLEEP_SHORT_CYCLES(20), .SLEEP_LONG_CYCLES(50))
    u_pd_msg_regs (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .controllerIdle(controllerIdle), .sleepActive(sleepActive),
    .pinLevelLo(pinLevelLo), .pinLevelHi(pinLevelHi),
    .pinDirOut(pinDirOut), .jackPin(jackPin),
    .jackEventEnable(jackEventEnable), .srcInfoUpdate(srcInfoUpdate),
    .srcInfoValue(srcInfoValue), .fwIdent(fwIdent),
    .hardwareRevisionWord(hwRev), .msgReq(msgReq), .msgKind(msgKind),
    .replyValid(replyValid), .reply(reply)
  );

  pd_partner_model u_pd_partner_model (
    .clk(clk), .msgReq(msgReq), .msgKind(msgKind)
  );

  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] ofs, input logic [1:0] w,
                    input logic [31:0] d);
    @(posedge clk);
    addr <= {ofs, w};
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic expRd(input logic [7:0] ofs, input logic [1:0] w,
                       input logic [31:0] e);
    @(posedge clk);
    addr <= {ofs, w};
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 `CHK(rdData, e)
  endtask

  // block contents left by the table rows, bit 111 reserved
  localparam logic [119:0] SCE_ROWS = {24'hff_7f13, {96{1'b1}}};

  function automatic reply_s expReply(msg_kind_e k, logic [2:0] en);
    reply_s r;
    logic ok;
    r = '0;
    r.kind = k;
    case (k)
      MSG_SRC_CAP_EXT: ok = en[EXT_CAP_EN_BIT];
      MSG_SRC_INFO: ok = en[SRC_INFO_EN_BIT];
      MSG_PPS_STATUS: ok = en[PPS_EN_BIT];
      default: ok = 1'b0;
    endcase
    r.notSupported = !ok;
    if (ok && k == MSG_SRC_CAP_EXT) r.payload = {fwIdent, hwRev, SCE_ROWS};
    if (ok && k == MSG_SRC_INFO) r.payload = REPLY_W'(32'h80ff_ffff);
    if (ok && k == MSG_PPS_STATUS) r.payload = REPLY_W'(32'h0eff_ffff);
    return r;
  endfunction

  task automatic msgCase(input msg_kind_e k, input logic [2:0] en);
    u_pd_partner_model.send(k, 1);
    #1 `CHK(replyValid, 1'b1)
    `CHK(reply, expReply(k, en))
    @(posedge clk);
    #1 `CHK(replyValid, 1'b0)
  endtask

  task automatic sleepCase(input logic [7:0] cfg, input int lo,
                           input int hi, input logic e);
    wr(OFS_SLEEP, 2'h0, {24'h0, cfg});
    @(posedge clk);
    controllerIdle <= 1'b1;
    repeat (lo) @(posedge clk);
    #1 `CHK(sleepActive, 1'b0)
    repeat (hi - lo) @(posedge clk);
    #1 `CHK(sleepActive, e)
    @(posedge clk);
    controllerIdle <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(sleepActive, 1'b0)
  endtask

  task automatic stopTest();
    if (nErrors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // some 500 cycles suffice; the ceiling cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      stopTest();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].ofs, rows[i].w, rows[i].d);
      expRd(rows[i].ofs, rows[i].w, rows[i].e);
    end
    expRd(OFS_SLEEP, 2'h0, 32'h0000_0004);
    @(posedge clk);
    srcInfoUpdate <= 1'b1;
    srcInfoValue <= 32'hffff_ffff;
    @(posedge clk);
    srcInfoUpdate <= 1'b0;
    expRd(OFS_SRC_INFO, 2'h0, 32'h80ff_ffff);
    for (int en = 0; en < 8; en++) begin
      wr(OFS_PROTO_CFG, 2'h0, 32'(en));
      for (int k = 0; k < 4; k++) begin
        msgCase(msg_kind_e'(k), 3'(en));
      end
    end
    pinLevelLo <= 8'ha5;
    pinLevelHi <= 3'h5;
    pinDirOut <= 8'h3c;
    repeat (4) @(posedge clk);
    expRd(OFS_PIN_STATE, 2'h0, 32'h0000_14a5);
    expRd(OFS_PIN_STATE, 2'h1, 32'h0000_003c);
    wr(OFS_SRC_CAP_EXT, 2'h2, 32'h0200_0000);
    jackEventEnable <= 1'b1;
    jackPin <= 1'b1;
    repeat (6) @(posedge clk);
    expRd(OFS_SRC_CAP_EXT, 2'h2, 32'h0300_0000);
    jackPin <= 1'b0;
    repeat (6) @(posedge clk);
    expRd(OFS_SRC_CAP_EXT, 2'h2, 32'h0200_0000);
    sleepCase(8'h03, 18, 26, 1'b1);
    sleepCase(8'h05, 48, 56, 1'b1);
    sleepCase(8'h02, 60, 60, 1'b0);
    sleepCase(8'h01, 60, 60, 1'b0);
    sleepCase(8'h07, 60, 60, 1'b0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    expRd(OFS_SLEEP, 2'h0, 32'h0000_0003);
    expRd(OFS_PROTO_CFG, 2'h0, 32'h0);
    expRd(OFS_PPS, 2'h0, 32'h0);
    expRd(OFS_SRC_INFO, 2'h0, 32'h0);
    expRd(OFS_SRC_CAP_EXT, 2'h3, 32'h0);
    stopTest();
  end
endmodule
`default_nettype wire

/* File: bench/pd_partner_model.sv */
`default_nettype none
module pd_partner_model
  import pd_regs_pkg::*;
(
  // clock
  input wire logic clk,
  // requests towards the controller
  output logic msgReq,
  output var msg_kind_e msgKind
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    msgReq = 1'b0;
    msgKind = MSG_PPS_STATUS;
  end

  // ------------------------------------------------------------
  // one request pulse
  // ------------------------------------------------------------
  // gap of at least one edge keeps two pulses from colliding;
  // idle kind shows the inverted code so a stale value never matches
  task automatic send(input msg_kind_e kind, input int gap);
    repeat (gap) @(posedge clk);
    msgReq <= 1'b1;
    msgKind <= kind;
    @(posedge clk);
    msgReq <= 1'b0;
    msgKind <= msg_kind_e'(~kind);
  endtask
endmodule
`default_nettype wire

/* File: common/pd_regs_pkg.sv */
`default_nettype none
package pd_regs_pkg;

  // ------------------------------------------------------------
  // register port geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int OFS_W = 8;
  localparam int WSEL_W = 2;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_PROTO_CFG = 8'h42;
  localparam logic [7:0] OFS_SLEEP = 8'h70;
  localparam logic [7:0] OFS_PIN_STATE = 8'h72;
  localparam logic [7:0] OFS_SRC_CAP_EXT = 8'h77;
  localparam logic [7:0] OFS_SRC_INFO = 8'h78;
  localparam logic [7:0] OFS_PPS = 8'h7a;

  // ------------------------------------------------------------
  // sleep control layout and timing
  // ------------------------------------------------------------
  localparam logic [7:0] SLEEP_RESET = 8'h03;
  localparam logic [7:0] SLEEP_WMASK = 8'h07;
  localparam int SLEEP_PERMIT_BIT = 0;
  localparam int SLEEP_CODE_LSB = 1;
  localparam logic [1:0] SLEEP_CODE_100MS = 2'h1;
  localparam logic [1:0] SLEEP_CODE_1000MS = 2'h2;
  localparam int SLEEP_SHORT_MS = 100;
  localparam int SLEEP_LONG_MS = 1000;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int SLEEP_SHORT_CYC = SLEEP_SHORT_MS * CYCLES_PER_MS;
  localparam int SLEEP_LONG_CYC = SLEEP_LONG_MS * CYCLES_PER_MS;
  localparam int SLEEP_CNT_W = 24;

  // ------------------------------------------------------------
  // protocol configuration enables
  // ------------------------------------------------------------
  localparam int EXT_CAP_EN_BIT = 0;
  localparam int SRC_INFO_EN_BIT = 1;
  localparam int PPS_EN_BIT = 2;
  localparam logic [31:0] PROTO_CFG_WMASK = 32'h0000_0007;

  // ------------------------------------------------------------
  // pin state, source info, supply status, extended block
  // ------------------------------------------------------------
  localparam int PIN_LO_N = 8;
  localparam int PIN_HI_N = 3;
  localparam int PIN_HI_LSB = 10;
  localparam int PIN_DIR_LSB = 32;
  localparam logic [31:0] SRC_INFO_MASK = 32'h80ff_ffff;
  localparam logic [31:0] PPS_WMASK = 32'h0eff_ffff;
  localparam int SCE_W = 120;
  localparam logic [119:0] SCE_WMASK =
    120'hff7f_ffff_ffff_ffff_ffff_ffff_ffff_ff;
  localparam int JACK_BIT = 88;
  localparam int FW_ID_W = 112;
  localparam int HW_REV_W = 16;
  // ids, revision word and the whole block must all fit
  localparam int REPLY_W = FW_ID_W + HW_REV_W + SCE_W;

  // ------------------------------------------------------------
  // message kinds and carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MSG_SRC_CAP_EXT = 2'b00,
    MSG_SRC_INFO = 2'b01,
    MSG_PPS_STATUS = 2'b10
  } msg_kind_e;

  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [31:0] xid;
    logic [31:0] fwVersion;
  } fw_ident_s;

  typedef struct packed {
    msg_kind_e kind;
    logic notSupported;
    logic [REPLY_W-1:0] payload;
  } reply_s;

endpackage
`default_nettype wire

/* File: core/pd_msg_regs.sv */
// Operation
// R01 - delay code 1=100ms, 2=1000ms, others reserved
// R02 - permit bit set: sleep after idle delay
// R03 - sleep control resets to 03h
// R04 - bits 39..32 show output direction pins 0-7
// R05 - level bits for pins 0-7, 10-12
// R06 - extended capability disabled: answer not supported
// R07 - extended reply: ids, versions, then block
// R08 - host keeps battery counts within limits
// R09 - jack event edges update source input bit0
// R10 - host may set source input bit1
// R11 - power ratings placed, bit 111 reserved
// R12 - remaining extended block fields placed as mapped
// R13 - source info disabled: not supported, else send
// R14 - source info updated internally, host read-only
// R15 - bit 31 capacity type, 30..24 reserved
// R16 - three power fields at 250mW per count
// R17 - supply status disabled: not supported, else send
// R18 - supply status reserved high nibble, flags writable
// R19 - reserved bits read zero, ignore writes
`default_nettype none
module pd_msg_regs
  import pd_regs_pkg::*;
#(
  parameter int SLEEP_SHORT_CYCLES = SLEEP_SHORT_CYC,
  parameter int SLEEP_LONG_CYCLES = SLEEP_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  // sleep
  input wire logic controllerIdle,
  output logic sleepActive,
  // pins
  input wire logic [PIN_LO_N-1:0] pinLevelLo,
  input wire logic [PIN_HI_N-1:0] pinLevelHi,
  input wire logic [PIN_LO_N-1:0] pinDirOut,
  input wire logic jackPin,
  input wire logic jackEventEnable,
  // internal source info update
  input wire logic srcInfoUpdate,
  input wire logic [DATA_W-1:0] srcInfoValue,
  // identity for extended reply
  input wire fw_ident_s fwIdent,
  input wire logic [15:0] hardwareRevisionWord,
  // partner requests and replies
  input wire logic msgReq,
  input wire msg_kind_e msgKind,
  output logic replyValid,
  output reply_s reply
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [DATA_W-1:0] protoCfg, next_protoCfg;
  logic [7:0] sleepCtl, next_sleepCtl;
  logic [SCE_W-1:0] sourceCapabilityExtended, next_sce;
  logic [DATA_W-1:0] sourcePowerInfo, next_sourcePowerInfo;
  logic [DATA_W-1:0] supplyStatus, next_supplyStatus;
  logic [DATA_W-1:0] next_rdData;
  logic [PIN_LO_N+PIN_HI_N-1:0] pinMeta, pinSync;
  logic jackMeta, jackSync, jackPrev;
  logic [SLEEP_CNT_W-1:0] idleCount, next_idleCount;
  logic next_sleepActive;
  logic next_replyValid;
  reply_s next_reply;

  logic [OFS_W-1:0] regOfs;
  logic [WSEL_W-1:0] wordSel;
  logic [63:0] pinState;
  logic [127:0] sceView;
  logic [1:0] sleepCode;
  logic sleepPermit;
  logic jackEdge;
  logic [SLEEP_CNT_W-1:0] sleepTarget;
  logic sleepCodeValid;
  logic wrWord0;

  assign regOfs = addr[ADDR_W-1:WSEL_W];
  assign wordSel = addr[WSEL_W-1:0];
  assign wrWord0 = wrStrobe && wordSel == '0;
  assign sleepCode = sleepCtl[SLEEP_CODE_LSB +: 2];
  assign sleepPermit = sleepCtl[SLEEP_PERMIT_BIT];
  assign sceView = {8'h00, sourceCapabilityExtended};
  assign jackEdge = jackSync ^ jackPrev;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= '0;
      pinSync <= '0;
      jackMeta <= 1'b0;
      jackSync <= 1'b0;
      jackPrev <= 1'b0;
    end else begin
      pinMeta <= {pinLevelHi, pinLevelLo};
      pinSync <= pinMeta;
      jackMeta <= jackPin;
      jackSync <= jackMeta;
      jackPrev <= jackSync;
    end
  end

  // R04 direction bits
  // R05 level bits, 9..8 stay zero
  always_comb begin
    pinState = '0;
    pinState[PIN_DIR_LSB +: PIN_LO_N] = pinDirOut;
    pinState[PIN_LO_N-1:0] = pinSync[PIN_LO_N-1:0];
    pinState[PIN_HI_LSB +: PIN_HI_N] = pinSync[PIN_LO_N +: PIN_HI_N];
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_comb begin
    next_protoCfg = protoCfg;
    next_sleepCtl = sleepCtl;
    next_sce = sourceCapabilityExtended;
    next_sourcePowerInfo = sourcePowerInfo;
    next_supplyStatus = supplyStatus;
    if (wrStrobe) begin
      unique case (regOfs)
        OFS_PROTO_CFG: if (wrWord0) next_protoCfg = wrData & PROTO_CFG_WMASK;
        // R19 reserved sleep bits and unmapped words dropped
        OFS_SLEEP: if (wrWord0) next_sleepCtl = wrData[7:0] & SLEEP_WMASK;
        // R11 bit 111 masked on write
        // R12 fields stored at mapped positions
        OFS_SRC_CAP_EXT: begin
          for (int w = 0; w < 4; w++) begin
            if (wordSel == w[WSEL_W-1:0]) begin
              if (w == 3) begin
                next_sce[119:96] = wrData[23:0] & SCE_WMASK[119:96];
              end else begin
                next_sce[w*32 +: 32] = wrData & SCE_WMASK[w*32 +: 32];
              end
            end
          end
        end
        // R18 reserved bits masked
        OFS_PPS: if (wrWord0) next_supplyStatus = wrData & PPS_WMASK;
        default: ;
      endcase
    end
    // R14 host writes cannot reach source info
    // R15 reserved capacity bits forced zero
    if (srcInfoUpdate) begin
      next_sourcePowerInfo = srcInfoValue & SRC_INFO_MASK;
    end
    // R09 jack edge wins over a same-cycle host write
    if (jackEventEnable && jackEdge) begin
      next_sce[JACK_BIT] = jackSync;
    end
  end

  // R03 sleep control reset value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      protoCfg <= '0;
      sleepCtl <= SLEEP_RESET;
      sourceCapabilityExtended <= '0;
      sourcePowerInfo <= '0;
      supplyStatus <= '0;
    end else begin
      protoCfg <= next_protoCfg;
      sleepCtl <= next_sleepCtl;
      sourceCapabilityExtended <= next_sce;
      sourcePowerInfo <= next_sourcePowerInfo;
      supplyStatus <= next_supplyStatus;
    end
  end

  // ------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ------------------------------------------------------------
  // R19 unmapped words and reserved bits read zero
  always_comb begin
    next_rdData = '0;
    if (rdStrobe) begin
      unique case (regOfs)
        OFS_PROTO_CFG: next_rdData = (wordSel == '0) ? protoCfg : '0;
        OFS_SLEEP: next_rdData = (wordSel == '0) ? {24'h0, sleepCtl} : '0;
        OFS_PIN_STATE: begin
          if (wordSel == 2'h0) begin
            next_rdData = pinState[31:0];
          end else if (wordSel == 2'h1) begin
            next_rdData = pinState[63:32];
          end
        end
        OFS_SRC_CAP_EXT: next_rdData = sceView[wordSel*32 +: 32];
        OFS_SRC_INFO: next_rdData = (wordSel == '0) ? sourcePowerInfo : '0;
        OFS_PPS: next_rdData = (wordSel == '0) ? supplyStatus : '0;
        default: next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ------------------------------------------------------------
  // sleep entry
  // ------------------------------------------------------------
  // R01 delay code selects target, reserved codes never sleep
  always_comb begin
    sleepCodeValid = 1'b1;
    sleepTarget = SLEEP_CNT_W'(SLEEP_SHORT_CYCLES);
    if (sleepCode == SLEEP_CODE_1000MS) begin
      sleepTarget = SLEEP_CNT_W'(SLEEP_LONG_CYCLES);
    end else if (sleepCode != SLEEP_CODE_100MS) begin
      sleepCodeValid = 1'b0;
    end
  end

  // R02 idle time counted only while permitted
  always_comb begin
    next_idleCount = idleCount;
    next_sleepActive = 1'b0;
    if (!controllerIdle || !sleepPermit || !sleepCodeValid) begin
      next_idleCount = '0;
    end else if (idleCount < sleepTarget) begin
      next_idleCount = idleCount + 1'b1;
    end else begin
      next_sleepActive = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idleCount <= '0;
      sleepActive <= 1'b0;
    end else begin
      idleCount <= next_idleCount;
      sleepActive <= next_sleepActive;
    end
  end

  // ------------------------------------------------------------
  // partner message replies
  // ------------------------------------------------------------
  always_comb begin
    next_replyValid = msgReq;
    next_reply = reply;
    if (msgReq) begin
      next_reply.kind = msgKind;
      next_reply.notSupported = 1'b1;
      next_reply.payload = '0;
      unique case (msgKind)
        // R06 disabled extended capability
        // R07 ids and versions ahead of the block
        MSG_SRC_CAP_EXT: begin
          if (protoCfg[EXT_CAP_EN_BIT]) begin
            next_reply.notSupported = 1'b0;
            next_reply.payload = {fwIdent.vid, fwIdent.pid, fwIdent.xid,
              fwIdent.fwVersion, hardwareRevisionWord,
              sourceCapabilityExtended};
          end
        end
        // R13 source info gated by its enable
        // R16 power fields sent as stored
        MSG_SRC_INFO: begin
          if (protoCfg[SRC_INFO_EN_BIT]) begin
            next_reply.notSupported = 1'b0;
            next_reply.payload = {{(REPLY_W-DATA_W){1'b0}}, sourcePowerInfo};
          end
        end
        // R17 supply status gated by its enable
        MSG_PPS_STATUS: begin
          if (protoCfg[PPS_EN_BIT]) begin
            next_reply.notSupported = 1'b0;
            next_reply.payload = {{(REPLY_W-DATA_W){1'b0}}, supplyStatus};
          end
        end
        default: next_reply.notSupported = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      replyValid <= 1'b0;
      reply <= '0;
    end else begin
      replyValid <= next_replyValid;
      reply <= next_reply;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence seqExtReqOff;
    msgReq && msgKind == MSG_SRC_CAP_EXT && !protoCfg[EXT_CAP_EN_BIT];
  endsequence

  sequence seqNotSupReply;
    replyValid && reply.notSupported;
  endsequence

  chk_ext_cap_off: assert property ( // R06
    @(posedge clk) disable iff (!rst_b) seqExtReqOff |=> seqNotSupReply)
    else $error("extended capability request not refused");

  chk_ext_cap_body: assert property ( // R07
    @(posedge clk) disable iff (!rst_b)
    msgReq && msgKind == MSG_SRC_CAP_EXT && protoCfg[EXT_CAP_EN_BIT]
    |=> replyValid && !reply.notSupported
    && reply.payload[SCE_W +: 16] == $past(hardwareRevisionWord))
    else $error("extended reply lacks hardware revision");

  chk_sleep_blocked: assert property ( // R02
    @(posedge clk) disable iff (!rst_b)
    !sleepPermit |=> !sleepActive)
    else $error("sleep entered while not permitted");

  chk_sleep_delay: assert property ( // R01
    @(posedge clk) disable iff (!rst_b)
    $rose(sleepActive) |-> $past(idleCount) == $past(sleepTarget)
    && $past(sleepCodeValid))
    else $error("sleep entered before delay expired");

  chk_sleep_resv: assert property ( // R19
    @(posedge clk) disable iff (!rst_b)
    sleepCtl[7:3] == '0)
    else $error("sleep control reserved bits set");

  chk_dir_read: assert property ( // R04
    @(posedge clk) disable iff (!rst_b)
    rdStrobe && regOfs == OFS_PIN_STATE && wordSel == 2'h1
    |=> rdData == {24'h0, $past(pinDirOut)})
    else $error("direction bits misread");

  chk_level_read: assert property ( // R05
    @(posedge clk) disable iff (!rst_b)
    rdStrobe && regOfs == OFS_PIN_STATE && wordSel == 2'h0
    |=> rdData[9:8] == 2'b00 && rdData[7:0] == $past(pinSync[7:0]))
    else $error("level bits misread");

  chk_jack_edge: assert property ( // R09
    @(posedge clk) disable iff (!rst_b)
    jackEventEnable && jackEdge
    |=> sourceCapabilityExtended[JACK_BIT] == $past(jackSync))
    else $error("jack edge did not update source input");

  chk_info_host_ro: assert property ( // R14
    @(posedge clk) disable iff (!rst_b)
    !srcInfoUpdate |=> $stable(sourcePowerInfo))
    else $error("source info changed without internal update");

  chk_info_gate: assert property ( // R13
    @(posedge clk) disable iff (!rst_b)
    msgReq && msgKind == MSG_SRC_INFO
    |=> replyValid && reply.notSupported == !$past(protoCfg[SRC_INFO_EN_BIT]))
    else $error("source info reply gating wrong");

  chk_pps_gate: assert property ( // R17
    @(posedge clk) disable iff (!rst_b)
    msgReq && msgKind == MSG_PPS_STATUS && protoCfg[PPS_EN_BIT]
    |=> !reply.notSupported && reply.payload[31:0] == $past(supplyStatus))
    else $error("supply status reply wrong");

  chk_resv_zero: assert property ( // R19
    @(posedge clk) disable iff (!rst_b)
    supplyStatus[31:28] == '0 && !sourceCapabilityExtended[111]
    && sourcePowerInfo[30:24] == '0)
    else $error("reserved bits hold ones");

endmodule
`default_nettype wire
